// >>> sim/clock_mode_monitor.sv
`default_nettype none
module clock_mode_monitor
	import clock_mode_pkg::*;
(
	input wire logic     pclk,                       // clock
	input wire logic     presetn,                    // reset, active low
	input wire logic     halt_req,                   // halt pulse
	input wire logic     wake_req,                   // wake pulse
	input wire logic     watchdog_enable,            // watchdog on
	input wire osc_run_t osc_run,                    // oscillator enables
	input wire logic     core_clk_on,                // core gate
	input wire logic     high_speed_clock_on,        // fast gate
	input wire logic     low_speed_clock_on,         // slow gate
	input wire op_mode_t mode,                       // operating mode
	input wire logic     cpu_hold,                   // execution held
	input wire logic     state_retain,               // state frozen
	input wire logic     power_down_flag_set,        // pulse
	input wire logic     watchdog_expiry_flag_clear, // pulse
	input wire logic     watchdog_clear              // pulse
);
	timeunit 1ns;
	timeprecision 1ns;
	default clocking cb @(posedge pclk); endclocking
	default disable iff (!presetn);
	logic run_mode;
	assign run_mode = (mode == MODE_FAST) || (mode == MODE_SLOW);
	////////////////////////////////////////////////////////////////
	halt_pulse_a: assert property (
		halt_req && run_mode |=> power_down_flag_set && watchdog_expiry_flag_clear && watchdog_clear)
		else $error("halt entry pulses missing");
	pulse_short_a: assert property (
		power_down_flag_set |=> !power_down_flag_set && !watchdog_clear) else $error("halt pulse too long");
	halt_hold_a: assert property (
		halt_req && run_mode |-> ##2 cpu_hold && state_retain && !run_mode) else $error("halt not entered");
	wake_back_a: assert property (
		wake_req && cpu_hold |-> ##2 run_mode && !cpu_hold) else $error("wake not taken");
	sleep_gates_a: assert property (
		mode == MODE_SLEEP |-> !core_clk_on && !high_speed_clock_on && !low_speed_clock_on)
		else $error("clock running in sleep");
	idle_slow_a: assert property (
		mode == MODE_IDLE_SLOW |-> !high_speed_clock_on && low_speed_clock_on
		&& !osc_run.internal_fast_rc_osc && !osc_run.external_fast_crystal) else $error("idle slow gates wrong");
	idle_both_a: assert property (
		mode == MODE_IDLE_BOTH |-> core_clk_on && high_speed_clock_on && low_speed_clock_on)
		else $error("idle both gates wrong");
	idle_fast_a: assert property (
		mode == MODE_IDLE_FAST |-> high_speed_clock_on && !low_speed_clock_on) else $error("idle fast gates wrong");
	slow_rc_wd_a: assert property (
		watchdog_enable [*2] |-> osc_run.internal_slow_rc_osc) else $error("slow rc off with watchdog");
	cover property (mode == MODE_SLEEP);
	cover property (mode == MODE_IDLE_SLOW);
	cover property (mode == MODE_IDLE_FAST);
endmodule

bind system_clock_mode_control clock_mode_monitor mon (.pclk, .presetn, .halt_req, .wake_req, .watchdog_enable,
	.osc_run, .core_clk_on, .high_speed_clock_on, .low_speed_clock_on, .mode, .cpu_hold, .state_retain,
	.power_down_flag_set, .watchdog_expiry_flag_clear, .watchdog_clear);
`default_nettype wire

// >>> sim/osc_model.sv
`default_nettype none
module osc_model
	import clock_mode_pkg::*;
#(
	parameter int DELAY = 8
) (
	input  wire logic     pclk,    // clock
	input  wire logic     presetn, // reset, active low
	input  wire osc_run_t osc_run, // run enables from the block
	output logic [3:0]    ready    // stable per oscillator, osc_run order
);
	timeunit 1ns;
	timeprecision 1ns;
	logic [3:0]      run;
	logic [3:0][4:0] cnt;
	assign run = osc_run;
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cnt <= '0;
		end else begin
			for (int i = 0; i < 4; i++) begin
				if (!run[i]) cnt[i] <= 5'h00;
				else if (cnt[i] != 5'(DELAY)) cnt[i] <= cnt[i] + 5'h01;
			end
		end
	end
	// stable some time after start, dropped at once when stopped
	always_comb begin
		for (int i = 0; i < 4; i++) ready[i] = run[i] && (cnt[i] == 5'(DELAY));
	end
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
`default_nettype none
module tb_top
	import clock_mode_pkg::*;
;
	timeunit 1ns;
	timeprecision 1ns;
	logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
	logic        halt_req = 1'b0, wake_req = 1'b0, watchdog_enable = 1'b0;
	logic [11:0] paddr = 12'h000;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic        pready, pslverr, err, fast_crystal_range, core_clk_on, high_speed_clock_on, low_speed_clock_on;
	logic        cpu_hold, state_retain, power_down_flag_set, watchdog_expiry_flag_clear, watchdog_clear;
	logic [1:0]  fast_rc_freq_select;
	logic [3:0]  ready;
	osc_run_t    osc_run;
	core_route_t core_route;
	op_mode_t    mode;
	int          n_fail = 0, comparisons = 0, cycles = 0;
	system_clock_mode_control dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready,
		.pslverr, .halt_req, .wake_req, .watchdog_enable, .fast_rc_ready(ready[3]), .fast_xtal_ready(ready[2]),
		.slow_rc_ready(ready[1]), .slow_xtal_ready(ready[0]), .osc_run, .fast_rc_freq_select, .fast_crystal_range,
		.core_route, .core_clk_on, .high_speed_clock_on, .low_speed_clock_on, .mode, .cpu_hold, .state_retain,
		.power_down_flag_set, .watchdog_expiry_flag_clear, .watchdog_clear);
	osc_model osc (.pclk, .presetn, .osc_run, .ready);
	always #10 pclk = ~pclk;
	////////////////////////////////////////////////////////////////
	task automatic give_verdict;
		$display("Checks %0d, errors %0d", comparisons, n_fail);
		if (n_fail == 0 && comparisons > 0) $display("Simulation passed");
		else $display("Simulation failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		comparisons++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic apb(input logic w, input logic [11:0] a, input logic [7:0] d);
		@(posedge pclk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= {24'h0, d};
		@(posedge pclk);
		penable <= 1'b1;
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	task automatic rdchk(input logic [11:0] a, input logic [7:0] exp);
		apb(1'b0, a, 8'h00);
		chk(rd, {24'h0, exp});
	endtask
	task automatic osc_cycle(input logic [11:0] a, input logic [7:0] d);
		apb(1'b1, a, d);
		rdchk(a, d);
		repeat (20) @(posedge pclk);
		rdchk(a, d | 8'h02);
	endtask
	////////////////////////////////////////////////////////////////
	task automatic t_regs;
		logic [7:0] expv [4] = '{8'h00, 8'h03, 8'h00, 8'h00};
		for (int i = 0; i < 4; i++) rdchk(12'(i * 4), expv[i]);
		apb(1'b0, 12'h014, 8'h00);
		chk({rd[30:0], err}, 32'h1);
	endtask
	task automatic t_osc;
		apb(1'b1, 12'h004, 8'h00);
		rdchk(12'h004, 8'h00);
		chk(osc_run.internal_fast_rc_osc, 1'b0);
		osc_cycle(12'h004, 8'h05);
		for (int c = 0; c < 4; c++) begin
			apb(1'b1, 12'h004, {4'h0, c[1:0], 2'b01});
			repeat (2) @(posedge pclk);
			chk(fast_rc_freq_select, c[1:0]);
		end
		apb(1'b1, 12'h008, 8'h04);
		osc_cycle(12'h008, 8'h05);
		apb(1'b1, 12'h008, 8'h01);
		rdchk(12'h008, 8'h07);
		chk({fast_crystal_range, osc_run.external_fast_crystal}, 2'h3);
		osc_cycle(12'h00c, 8'h01);
		chk(osc_run.external_slow_crystal, 1'b1);
		apb(1'b1, 12'h004, 8'hff);
		rdchk(12'h004, 8'h0f);
	endtask
	task automatic t_switch;
		apb(1'b1, 12'h000, 8'hff);
		rdchk(12'h000, 8'hef);
		for (int i = 0; i < 8; i++) begin
			apb(1'b1, 12'h000, {i[2:0], 5'h0c});
			repeat (5) @(posedge pclk);
			chk(core_route, {2'b11, i == 7, (i == 7) ? 3'h6 : i[2:0]});
		end
		apb(1'b0, 12'h010, 8'h00);
		chk({rd[6:4], rd[2:0]}, {3'h7, MODE_SLOW});
	endtask
	task automatic halt_case(input logic [1:0] bits, input logic wd, input logic [5:0] exp);
		watchdog_enable <= wd;
		apb(1'b1, 12'h000, {6'h00, bits});
		repeat (5) @(posedge pclk);
		halt_req <= 1'b1;
		@(posedge pclk);
		halt_req <= 1'b0;
		#1 chk({power_down_flag_set, watchdog_expiry_flag_clear, watchdog_clear}, 3'h7);
		@(posedge pclk);
		#1 chk({mode, core_clk_on, high_speed_clock_on, low_speed_clock_on, cpu_hold, state_retain,
			osc_run.internal_slow_rc_osc}, {exp, 2'b11, exp[0] | wd});
		rdchk(12'h000, {6'h00, bits});
		wake_req <= 1'b1;
		@(posedge pclk);
		wake_req <= 1'b0;
		@(posedge pclk);
		#1 chk({mode, cpu_hold}, {MODE_FAST, 1'b0});
	endtask
	////////////////////////////////////////////////////////////////
	always @(posedge pclk) begin
		cycles++;
		if (cycles == 4000) begin
			n_fail++;
			give_verdict;
		end
	end
	initial begin
		repeat (10) @(posedge pclk);
		presetn <= 1'b1;
		repeat (20) @(posedge pclk);
		t_regs;
		t_osc;
		t_switch;
		halt_case(2'b00, 1'b1, {MODE_SLEEP, 3'b000});
		halt_case(2'b01, 1'b0, {MODE_IDLE_SLOW, 3'b001});
		halt_case(2'b11, 1'b0, {MODE_IDLE_BOTH, 3'b111});
		halt_case(2'b10, 1'b0, {MODE_IDLE_FAST, 3'b110});
		give_verdict;
	end
endmodule
`default_nettype wire

// >>> src/clock_mode_pkg.sv
`default_nettype none
package clock_mode_pkg;

	// register byte addresses
	localparam logic [7:0] SYSTEM_CLOCK_CONTROL_ADDR = 8'h00;
	localparam logic [7:0] FAST_RC_CONTROL_ADDR      = 8'h04;
	localparam logic [7:0] FAST_CRYSTAL_CONTROL_ADDR = 8'h08;
	localparam logic [7:0] SLOW_CRYSTAL_CONTROL_ADDR = 8'h0c;
	localparam logic [7:0] MODE_STATUS_ADDR          = 8'h10;

	// system_clock_control fields
	localparam int CORE_SEL_HI        = 7;
	localparam int CORE_SEL_LO        = 5;
	localparam int FAST_SRC_BIT       = 3;
	localparam int SLOW_SRC_BIT       = 2;
	localparam int FAST_HALT_BIT      = 1;
	localparam int SLOW_HALT_BIT      = 0;
	// fast_rc_control fields
	localparam int RC_FREQ_HI         = 3;
	localparam int RC_FREQ_LO         = 2;
	localparam int RC_STABLE_BIT      = 1;
	localparam int RC_ENABLE_BIT      = 0;
	// fast_crystal_control fields
	localparam int XT_RANGE_BIT       = 2;
	localparam int XT_STABLE_BIT      = 1;
	localparam int XT_ENABLE_BIT      = 0;
	// slow_crystal_control fields
	localparam int LXT_STABLE_BIT     = 1;
	localparam int LXT_ENABLE_BIT     = 0;
	// mode status fields
	localparam int STAT_MODE_HI       = 2;
	localparam int STAT_MODE_LO       = 0;
	localparam int STAT_SEL_HI        = 6;
	localparam int STAT_SEL_LO        = 4;
	localparam int STAT_PENDING_BIT   = 7;

	// reset values
	localparam logic [2:0] CORE_SEL_RESET     = 3'h0;
	localparam logic       FAST_SRC_RESET     = 1'b0;
	localparam logic       SLOW_SRC_RESET     = 1'b0;
	localparam logic       FAST_HALT_RESET    = 1'b0;
	localparam logic       SLOW_HALT_RESET    = 1'b0;
	localparam logic [1:0] RC_FREQ_RESET      = 2'h0;
	localparam logic       RC_ENABLE_RESET    = 1'b1;
	localparam logic       XT_RANGE_RESET     = 1'b0;
	localparam logic       XT_ENABLE_RESET    = 1'b0;
	localparam logic       LXT_ENABLE_RESET   = 1'b0;

	localparam logic [2:0] CORE_SEL_SLOW      = 3'h7;

	typedef enum logic [2:0] {
		MODE_FAST       = 3'b000,
		MODE_SLOW       = 3'b001,
		MODE_SLEEP      = 3'b010,
		MODE_IDLE_SLOW  = 3'b011,
		MODE_IDLE_BOTH  = 3'b100,
		MODE_IDLE_FAST  = 3'b101
	} op_mode_t;

	typedef struct packed {
		logic internal_fast_rc_osc;
		logic external_fast_crystal;
		logic internal_slow_rc_osc;
		logic external_slow_crystal;
	} osc_run_t;

	typedef struct packed {
		logic       fast_source_select;
		logic       slow_source_select;
		logic       use_low_speed;
		logic [2:0] fast_divide_code;
	} core_route_t;

endpackage
`default_nettype wire

// >>> src/system_clock_mode_control.sv
// Function
// - select bits 7..5 pick fast clock divided 1..64, or slow clock at 111
// - bit 3 picks fast RC at 0, fast crystal at 1
// - bit 2 picks slow RC at 0, 32 kHz crystal at 1
// - bit 1 keeps fast oscillator running through halt when set
// - bit 0 keeps slow oscillator in halt; slow RC also runs with watchdog on
// - fast RC frequency field bits 3..2: 4, 8, 12, 4 MHz
// - fast RC stable flag reads 0 after enable, 1 once oscillator stable
// - fast RC enable bit turns oscillator off/on, resets to 1
// - crystal range set before enabling crystal; changes while enabled are ignored
// - fast crystal stable flag reads 0 after enable, 1 once stable
// - 32 kHz crystal stable flag reads 0 after enable, 1 once stable
// - fast and slow crystal enables turn oscillators off/on, reset to 0
// - unimplemented bits of the four control registers read 0
// - halt with both halt bits 0 enters sleep, core clock stopped, cpu held
// - halt with fast bit 0, slow bit 1 enters slow-only idle
// - any halt entry sets power-down flag, clears watchdog expiry flag
// - any halt entry clears watchdog counter; it resumes only if enabled
// - during halt modes memory, registers and ports are held unchanged
// - select 111 moves core to slow clock once slow source stable
// - select 000..110 returns to divided fast clock once fast source stable flag set
// - halt with both halt bits 1 enters idle with both clocks running
// - halt with fast bit 1, slow bit 0 enters fast-only idle
//
// Implementation choices: the register addresses and register access over APB.
`default_nettype none
module system_clock_mode_control
	import clock_mode_pkg::*;
#(
	parameter int ADDR_W = 12
) (
	input  wire logic          pclk,                 // bus and control clock
	input  wire logic          presetn,              // power-on reset, active low
	input  wire logic          psel,                 // apb select
	input  wire logic          penable,              // apb access phase
	input  wire logic          pwrite,               // apb write
	input  wire logic [ADDR_W-1:0] paddr,            // apb byte address
	input  wire logic [31:0]   pwdata,               // apb write data
	output logic      [31:0]   prdata,               // apb read data
	output logic               pready,               // apb ready
	output logic               pslverr,              // apb error on unmapped address
	input  wire logic          halt_req,             // cpu halt instruction pulse
	input  wire logic          wake_req,             // wake-up pulse from wake logic
	input  wire logic          watchdog_enable,      // watchdog function enabled
	input  wire logic          fast_rc_ready,        // fast rc oscillator stable, async
	input  wire logic          fast_xtal_ready,      // fast crystal stable, async
	input  wire logic          slow_rc_ready,        // slow rc oscillator stable, async
	input  wire logic          slow_xtal_ready,      // 32 kHz crystal stable, async
	output osc_run_t           osc_run,              // oscillator run enables
	output logic      [1:0]    fast_rc_freq_select,  // fast rc frequency trim
	output logic               fast_crystal_range,   // crystal above 10 MHz mode
	output core_route_t        core_route,           // active core clock mux setting
	output logic               core_clk_on,          // core clock gate enable
	output logic               high_speed_clock_on,  // fast clock tree gate enable
	output logic               low_speed_clock_on,   // slow clock tree gate enable
	output op_mode_t           mode,                 // current operating mode
	output logic               cpu_hold,             // stop execution at halt
	output logic               state_retain,         // freeze memory, registers, ports
	output logic               power_down_flag_set,  // pulse: set status power-down flag
	output logic               watchdog_expiry_flag_clear, // pulse: clear expiry flag
	output logic               watchdog_clear        // pulse: clear watchdog counter
);

	if (ADDR_W < 5 || ADDR_W > 32) begin : g_addr_w_check
		$error("ADDR_W must lie between 5 and 32");
	end

	////////////////////////////////////////////////////////////////////////////
	// helpers

	// flag reads 0 the cycle enable rises, then tracks the synced ready
	function automatic logic stable_next(input logic en_old, input logic en_new, input logic ready);
		return en_old & en_new & ready;
	endfunction

	function automatic logic addr_hit(input logic [ADDR_W-1:0] a, input logic [7:0] target);
		return a == ADDR_W'(target);
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// synchronisers for oscillator ready levels

	logic [3:0] ready_meta_reg;
	logic [3:0] ready_sync_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ready_meta_reg <= 4'h0;
			ready_sync_reg <= 4'h0;
		end else begin
			ready_meta_reg <= {fast_rc_ready, fast_xtal_ready, slow_rc_ready, slow_xtal_ready};
			ready_sync_reg <= ready_meta_reg;
		end
	end

	logic fast_rc_rdy_s;
	logic fast_xt_rdy_s;
	logic slow_rc_rdy_s;
	logic slow_xt_rdy_s;
	assign {fast_rc_rdy_s, fast_xt_rdy_s, slow_rc_rdy_s, slow_xt_rdy_s} = ready_sync_reg;

	////////////////////////////////////////////////////////////////////////////
	// apb decode

	logic wr_en;
	logic hit_scc;
	logic hit_rc;
	logic hit_xt;
	logic hit_lxt;
	logic hit_stat;
	logic hit_any;

	assign wr_en    = psel & penable & pwrite;
	assign hit_scc  = addr_hit(paddr, SYSTEM_CLOCK_CONTROL_ADDR);
	assign hit_rc   = addr_hit(paddr, FAST_RC_CONTROL_ADDR);
	assign hit_xt   = addr_hit(paddr, FAST_CRYSTAL_CONTROL_ADDR);
	assign hit_lxt  = addr_hit(paddr, SLOW_CRYSTAL_CONTROL_ADDR);
	assign hit_stat = addr_hit(paddr, MODE_STATUS_ADDR);
	assign hit_any  = hit_scc | hit_rc | hit_xt | hit_lxt | hit_stat;
	assign pready   = 1'b1;
	assign pslverr  = psel & penable & ~hit_any;

	////////////////////////////////////////////////////////////////////////////
	// control registers

	logic [2:0] core_clock_select_reg;
	logic       fast_source_select_reg;
	logic       slow_source_select_reg;
	logic       fast_osc_in_halt_reg;
	logic       slow_osc_in_halt_reg;
	logic [1:0] fast_rc_freq_select_reg;
	logic       fast_rc_enable_reg;
	logic       fast_crystal_range_reg;
	logic       fast_crystal_enable_reg;
	logic       slow_crystal_enable_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_clock_select_reg  <= CORE_SEL_RESET;
			fast_source_select_reg <= FAST_SRC_RESET;
			slow_source_select_reg <= SLOW_SRC_RESET;
			fast_osc_in_halt_reg   <= FAST_HALT_RESET;
			slow_osc_in_halt_reg   <= SLOW_HALT_RESET;
		end else if (wr_en && hit_scc) begin
			core_clock_select_reg  <= pwdata[CORE_SEL_HI:CORE_SEL_LO];
			fast_source_select_reg <= pwdata[FAST_SRC_BIT];
			slow_source_select_reg <= pwdata[SLOW_SRC_BIT];
			fast_osc_in_halt_reg   <= pwdata[FAST_HALT_BIT];
			slow_osc_in_halt_reg   <= pwdata[SLOW_HALT_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_rc_freq_select_reg <= RC_FREQ_RESET;
			fast_rc_enable_reg      <= RC_ENABLE_RESET;
		end else if (wr_en && hit_rc) begin
			fast_rc_freq_select_reg <= pwdata[RC_FREQ_HI:RC_FREQ_LO];
			fast_rc_enable_reg      <= pwdata[RC_ENABLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_crystal_range_reg  <= XT_RANGE_RESET;
			fast_crystal_enable_reg <= XT_ENABLE_RESET;
		end else if (wr_en && hit_xt) begin
			// range is frozen while the crystal enable bit is already set
			if (!fast_crystal_enable_reg)
				fast_crystal_range_reg <= pwdata[XT_RANGE_BIT];
			fast_crystal_enable_reg <= pwdata[XT_ENABLE_BIT];
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			slow_crystal_enable_reg <= LXT_ENABLE_RESET;
		else if (wr_en && hit_lxt)
			slow_crystal_enable_reg <= pwdata[LXT_ENABLE_BIT];
	end

	////////////////////////////////////////////////////////////////////////////
	// stable flags

	logic fast_rc_stable_reg;
	logic fast_crystal_stable_reg;
	logic slow_crystal_stable_reg;
	logic fast_rc_en_d_reg;
	logic fast_xt_en_d_reg;
	logic slow_xt_en_d_reg;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fast_rc_en_d_reg        <= 1'b0;
			fast_xt_en_d_reg        <= 1'b0;
			slow_xt_en_d_reg        <= 1'b0;
			fast_rc_stable_reg      <= 1'b0;
			fast_crystal_stable_reg <= 1'b0;
			slow_crystal_stable_reg <= 1'b0;
		end else begin
			fast_rc_en_d_reg        <= osc_run.internal_fast_rc_osc;
			fast_xt_en_d_reg        <= osc_run.external_fast_crystal;
			slow_xt_en_d_reg        <= osc_run.external_slow_crystal;
			fast_rc_stable_reg      <= stable_next(fast_rc_en_d_reg, osc_run.internal_fast_rc_osc,
				fast_rc_rdy_s);
			fast_crystal_stable_reg <= stable_next(fast_xt_en_d_reg, osc_run.external_fast_crystal,
				fast_xt_rdy_s);
			slow_crystal_stable_reg <= stable_next(slow_xt_en_d_reg, osc_run.external_slow_crystal,
				slow_xt_rdy_s);
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// operating mode state machine

	op_mode_t   mode_reg;
	logic       halted;
	logic       halt_entry;
	logic [2:0] active_sel_reg;

	assign halted     = (mode_reg != MODE_FAST) && (mode_reg != MODE_SLOW);
	assign halt_entry = halt_req && !halted;

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			mode_reg <= MODE_FAST;
		end else if (halt_entry) begin
			unique case ({fast_osc_in_halt_reg, slow_osc_in_halt_reg})
				2'b00: mode_reg <= MODE_SLEEP;
				2'b01: mode_reg <= MODE_IDLE_SLOW;
				2'b11: mode_reg <= MODE_IDLE_BOTH;
				2'b10: mode_reg <= MODE_IDLE_FAST;
			endcase
		end else if (halted && wake_req) begin
			mode_reg <= (active_sel_reg == CORE_SEL_SLOW) ? MODE_SLOW : MODE_FAST;
		end else if (!halted) begin
			mode_reg <= (active_sel_reg == CORE_SEL_SLOW) ? MODE_SLOW : MODE_FAST;
		end
	end

	// one-cycle pulses to the status and watchdog logic on every halt entry
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			power_down_flag_set        <= 1'b0;
			watchdog_expiry_flag_clear <= 1'b0;
			watchdog_clear             <= 1'b0;
		end else begin
			power_down_flag_set        <= halt_entry;
			watchdog_expiry_flag_clear <= halt_entry;
			watchdog_clear             <= halt_entry;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// core clock source switching

	logic target_stable;
	logic switch_pending;

	// slow rc has no flag of its own; its synced ready stands in for one
	always_comb begin
		if (core_clock_select_reg == CORE_SEL_SLOW)
			target_stable = slow_source_select_reg ? slow_crystal_stable_reg : slow_rc_rdy_s;
		else
			target_stable = fast_source_select_reg ? fast_crystal_stable_reg : fast_rc_stable_reg;
	end

	assign switch_pending = core_clock_select_reg != active_sel_reg;

	// old selection stays in force until the new source is stable
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn)
			active_sel_reg <= CORE_SEL_RESET;
		else if (switch_pending && target_stable && !halted)
			active_sel_reg <= core_clock_select_reg;
	end

	////////////////////////////////////////////////////////////////////////////
	// oscillator and clock gate outputs

	logic fast_on_next;
	logic slow_on_next;
	logic core_on_next;

	always_comb begin
		fast_on_next = 1'b1;
		slow_on_next = 1'b1;
		core_on_next = 1'b1;
		unique case (mode_reg)
			MODE_FAST, MODE_SLOW: begin
				fast_on_next = 1'b1;
				slow_on_next = 1'b1;
				core_on_next = 1'b1;
			end
			MODE_SLEEP: begin
				fast_on_next = 1'b0;
				slow_on_next = 1'b0;
				core_on_next = 1'b0;
			end
			MODE_IDLE_SLOW: begin
				fast_on_next = 1'b0;
				slow_on_next = 1'b1;
				core_on_next = active_sel_reg == CORE_SEL_SLOW;
			end
			MODE_IDLE_BOTH: begin
				fast_on_next = 1'b1;
				slow_on_next = 1'b1;
				core_on_next = 1'b1;
			end
			MODE_IDLE_FAST: begin
				fast_on_next = 1'b1;
				slow_on_next = 1'b0;
				core_on_next = active_sel_reg != CORE_SEL_SLOW;
			end
			default: begin
				fast_on_next = 1'b1;
				slow_on_next = 1'b1;
				core_on_next = 1'b1;
			end
		endcase
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			osc_run             <= '{internal_fast_rc_osc: RC_ENABLE_RESET, external_fast_crystal: XT_ENABLE_RESET,
				internal_slow_rc_osc: 1'b1, external_slow_crystal: LXT_ENABLE_RESET};
			high_speed_clock_on <= 1'b1;
			low_speed_clock_on  <= 1'b1;
			core_clk_on         <= 1'b1;
		end else begin
			osc_run.internal_fast_rc_osc  <= fast_rc_enable_reg & fast_on_next;
			osc_run.external_fast_crystal <= fast_crystal_enable_reg & fast_on_next;
			osc_run.internal_slow_rc_osc  <= slow_on_next | watchdog_enable;
			osc_run.external_slow_crystal <= slow_crystal_enable_reg & slow_on_next;
			high_speed_clock_on <= fast_on_next;
			low_speed_clock_on  <= slow_on_next;
			core_clk_on         <= core_on_next;
		end
	end

	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			core_route          <= '{fast_source_select: FAST_SRC_RESET, slow_source_select: SLOW_SRC_RESET,
				use_low_speed: 1'b0, fast_divide_code: CORE_SEL_RESET};
			fast_rc_freq_select <= RC_FREQ_RESET;
			fast_crystal_range  <= XT_RANGE_RESET;
			cpu_hold            <= 1'b0;
			state_retain        <= 1'b0;
			mode                <= MODE_FAST;
		end else begin
			core_route.fast_source_select <= fast_source_select_reg;
			core_route.slow_source_select <= slow_source_select_reg;
			core_route.use_low_speed      <= active_sel_reg == CORE_SEL_SLOW;
			core_route.fast_divide_code   <= (active_sel_reg == CORE_SEL_SLOW) ?
				core_route.fast_divide_code : active_sel_reg;
			fast_rc_freq_select <= fast_rc_freq_select_reg;
			fast_crystal_range  <= fast_crystal_range_reg;
			cpu_hold            <= halted;
			state_retain        <= halted;
			mode                <= mode_reg;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read data, unimplemented bits zero

	always_comb begin
		prdata = 32'h0000_0000;
		if (psel && !pwrite) begin
			if (hit_scc) begin
				prdata[CORE_SEL_HI:CORE_SEL_LO] = core_clock_select_reg;
				prdata[FAST_SRC_BIT]            = fast_source_select_reg;
				prdata[SLOW_SRC_BIT]            = slow_source_select_reg;
				prdata[FAST_HALT_BIT]           = fast_osc_in_halt_reg;
				prdata[SLOW_HALT_BIT]           = slow_osc_in_halt_reg;
			end else if (hit_rc) begin
				prdata[RC_FREQ_HI:RC_FREQ_LO]   = fast_rc_freq_select_reg;
				prdata[RC_STABLE_BIT]           = fast_rc_stable_reg;
				prdata[RC_ENABLE_BIT]           = fast_rc_enable_reg;
			end else if (hit_xt) begin
				prdata[XT_RANGE_BIT]            = fast_crystal_range_reg;
				prdata[XT_STABLE_BIT]           = fast_crystal_stable_reg;
				prdata[XT_ENABLE_BIT]           = fast_crystal_enable_reg;
			end else if (hit_lxt) begin
				prdata[LXT_STABLE_BIT]          = slow_crystal_stable_reg;
				prdata[LXT_ENABLE_BIT]          = slow_crystal_enable_reg;
			end else if (hit_stat) begin
				prdata[STAT_MODE_HI:STAT_MODE_LO] = mode_reg;
				prdata[STAT_SEL_HI:STAT_SEL_LO]   = active_sel_reg;
				prdata[STAT_PENDING_BIT]          = switch_pending;
			end
		end
	end

endmodule
`default_nettype wire
